// ===== hw/txfec_pkg.sv
// Shared constants and types of the transmit coding chain
package txfec_pkg;
  localparam int CHIP_RATE_MCPS = 560;
  localparam int SYM_RATE_MSPS  = CHIP_RATE_MCPS / 2;
  localparam int RS_MSG_BYTES   = 224;
  localparam int RS_PAR_BYTES   = 16;
  localparam logic [7:0] RS_POLY_LOW = 8'h1D;
  localparam logic [7:0] RS_ALPHA    = 8'h02;
  localparam logic [17:0] SEED_PRE = 18'h011A0;
  localparam logic [17:0] SEED_HDR = 18'h27BFA;
  localparam logic [17:0] SEED_PAY = 18'h3C859;
  localparam int LFSR_TAP_A = 9;
  localparam int LFSR_TAP_B = 6;
  localparam int LFSR_TAP_C = 4;
  localparam logic [2:0] CONV_G0 = 3'h7;
  localparam logic [2:0] CONV_G1 = 3'h5;
  localparam logic [4:0] SF_1  = 5'h01;
  localparam logic [4:0] SF_2  = 5'h02;
  localparam logic [4:0] SF_4  = 5'h04;
  localparam logic [4:0] SF_8  = 5'h08;
  localparam logic [4:0] SF_16 = 5'h10;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    RATE_522 = 3'h0,
    RATE_261 = 3'h1,
    RATE_130 = 3'h2,
    RATE_65  = 3'h3,
    RATE_32  = 3'h4
  } txfec_rate_t;

  typedef enum logic [1:0] {
    CONV_NONE   = 2'h0,
    CONV_SINGLE = 2'h1,
    CONV_DUAL   = 2'h2
  } txfec_conv_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE  = 4'h2,
    ST_HDR  = 4'h4,
    ST_PAY  = 4'h8
  } txfec_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } txfec_byte_t;

  typedef struct packed {
    logic       value;
    logic [1:0] phase;
  } txfec_chip_t;
endpackage

// ===== hw/txfec_rs_enc.sv
// Byte-wise shortened (240,224) Reed-Solomon systematic encoder
`timescale 1ns/1ns
module txfec_rs_enc
  import txfec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        in_valid,
  input  wire txfec_byte_t in_byte,
  output logic             in_ready,
  output logic             out_valid,
  output txfec_byte_t      out_byte,
  input  wire logic        out_ready
);
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ RS_POLY_LOW) : {x[6:0], 1'b0};
    end
    return p;
  endfunction

  // Coefficients g0..g15 of the product of (x - alpha^i), monic top term implied
  function automatic logic [RS_PAR_BYTES*8-1:0] gen_poly();
    logic [7:0] g [RS_PAR_BYTES+1];
    logic [7:0] root;
    logic [RS_PAR_BYTES*8-1:0] r;
    for (int j = 0; j <= RS_PAR_BYTES; j++)
      g[j] = 8'h00;
    g[0] = 8'h01;
    root = 8'h01;
    for (int i = 0; i < RS_PAR_BYTES; i++)
    begin
      for (int j = RS_PAR_BYTES; j > 0; j--)
        g[j] = g[j-1] ^ gf_mul(g[j], root);
      g[0] = gf_mul(g[0], root);
      root = gf_mul(root, RS_ALPHA);
    end
    for (int j = 0; j < RS_PAR_BYTES; j++)
      r[j*8 +: 8] = g[j];
    return r;
  endfunction

  localparam logic [RS_PAR_BYTES*8-1:0] GEN = gen_poly();

  typedef struct packed {
    logic [RS_PAR_BYTES-1:0][7:0] par;
    logic [7:0]                   cnt;
    logic                         parity_phase;
    logic                         blk_last;
    logic                         out_v;
    txfec_byte_t                  out_b;
  } txfec_rs_st_t;

  txfec_rs_st_t q;
  txfec_rs_st_t next_q;
  logic         slot_free;
  logic [7:0]   fb;

  assign slot_free = !q.out_v || out_ready;
  assign in_ready  = slot_free && !q.parity_phase;
  assign out_valid = q.out_v;
  assign out_byte  = q.out_b;

  always_comb
  begin
    next_q = q;
    fb = in_byte.data ^ q.par[RS_PAR_BYTES-1];
    if (q.out_v && out_ready)
      next_q.out_v = 1'b0;
    if (in_valid && in_ready)
    begin
      next_q.out_v = 1'b1;
      next_q.out_b = '{data: in_byte.data, last: 1'b0};
      next_q.par[0] = gf_mul(fb, GEN[7:0]);
      for (int j = 1; j < RS_PAR_BYTES; j++)
        next_q.par[j] = q.par[j-1] ^ gf_mul(fb, GEN[j*8 +: 8]);
      next_q.cnt = q.cnt + 8'h01;
      if (q.cnt == 8'(RS_MSG_BYTES - 1) || in_byte.last)
      begin
        next_q.parity_phase = 1'b1;
        next_q.blk_last = in_byte.last;
        next_q.cnt = 8'h00;
      end
    end
    else if (q.parity_phase && slot_free)
    begin
      next_q.out_v = 1'b1;
      next_q.out_b.data = q.par[RS_PAR_BYTES-1];
      next_q.out_b.last = 1'b0;
      next_q.par = {q.par[RS_PAR_BYTES-2:0], 8'h00};
      next_q.cnt = q.cnt + 8'h01;
      if (q.cnt == 8'(RS_PAR_BYTES - 1))
      begin
        next_q.out_b.last = q.blk_last;
        next_q.parity_phase = 1'b0;
        next_q.blk_last = 1'b0;
        next_q.cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end
endmodule // txfec_rs_enc

// ===== hw/txfec_chain.sv
// Transmit chain: RS encoder, convolutional coder, spreader, scrambler, chip phase
`timescale 1ns/1ns
module txfec_chain
  import txfec_pkg::*;
#(
  parameter int PRE_CHIPS = 512
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire txfec_rate_t RATE,
  input  wire logic        IN_VALID,
  input  wire txfec_byte_t IN_BYTE,
  output logic             IN_READY,
  output logic             CHIP_VALID,
  output txfec_chip_t      CHIP,
  output logic             BUSY,
  output logic             DONE
);
  import txfec_pkg::*;

  typedef struct packed {
    txfec_state_t st;
    txfec_rate_t  rate;
    logic [4:0]   spread_factor;
    txfec_conv_t  conv;
    logic [4:0]   chip_cnt;
    logic [17:0]  lfsr;
    logic [1:0]   phase;
    logic [15:0]  pre_cnt;
    logic         cur_v;
    logic         cur_last;
    logic [7:0]   cur_byte;
    logic [2:0]   bit_cnt;
    logic         half;
    logic         enc_sel;
    logic [1:0]   enc_a;
    logic [1:0]   enc_b;
    logic         hold_v;
    txfec_byte_t  hold;
    logic         chip_v;
    txfec_chip_t  chip;
    logic         done;
  } txfec_top_st_t;

  txfec_top_st_t q;
  txfec_top_st_t next_q;

  logic        rs_in_ready;
  logic        rs_out_valid;
  txfec_byte_t rs_out_byte;
  logic        rs_out_ready;
  logic        rs_in_valid;

  logic        coding;
  logic        last_seen;
  logic        fetch_ok;
  logic        src_v;
  txfec_byte_t src_b;
  logic        gen_bit;
  logic [17:0] gen_step;
  logic        in_bit;
  logic [1:0]  enc_cur;
  logic        coded;
  logic        last_coded;
  logic        byte_end;
  logic        part_end;

  txfec_rs_enc u_rs
  (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_valid  (rs_in_valid),
    .in_byte   (IN_BYTE),
    .in_ready  (rs_in_ready),
    .out_valid (rs_out_valid),
    .out_byte  (rs_out_byte),
    .out_ready (rs_out_ready)
  );

  // Stop fetching once the part's final byte is inside
  assign coding    = (q.st == ST_HDR) || (q.st == ST_PAY);
  assign last_seen = (q.cur_v && q.cur_last) || (q.hold_v && q.hold.last);
  assign fetch_ok  = coding && !q.hold_v && !last_seen;

  assign rs_in_valid  = IN_VALID && (q.st == ST_PAY);
  assign rs_out_ready = fetch_ok && (q.st == ST_PAY);
  assign IN_READY     = (q.st == ST_HDR) ? fetch_ok
                      : (q.st == ST_PAY) ? rs_in_ready
                      : 1'b0;

  assign src_v = (q.st == ST_HDR) ? IN_VALID : rs_out_valid;
  assign src_b = (q.st == ST_HDR) ? IN_BYTE : rs_out_byte;

  assign CHIP_VALID = q.chip_v;
  assign CHIP       = q.chip;
  assign BUSY       = (q.st != ST_IDLE);
  assign DONE       = q.done;

  function automatic logic [4:0] rate_sf(input txfec_rate_t r);
    case (r)
      RATE_522: return SF_1;
      RATE_261: return SF_1;
      RATE_130: return SF_2;
      RATE_65:  return SF_4;
      RATE_32:  return SF_8;
      default:  return SF_1;
    endcase
  endfunction

  function automatic txfec_conv_t rate_conv(input txfec_rate_t r);
    case (r)
      RATE_522: return CONV_NONE;
      RATE_261: return CONV_DUAL;
      default:  return CONV_SINGLE;
    endcase
  endfunction

  // Generator: out = stage 17, feedback x^18+x^10+x^7+x^5+1
  assign gen_bit  = q.lfsr[17];
  assign gen_step = {q.lfsr[16:0],
                     q.lfsr[17] ^ q.lfsr[LFSR_TAP_A] ^ q.lfsr[LFSR_TAP_B] ^ q.lfsr[LFSR_TAP_C]};

  assign in_bit  = q.cur_byte[7];
  assign enc_cur = (q.conv == CONV_DUAL && q.enc_sel) ? q.enc_b : q.enc_a;
  assign coded   = (q.conv == CONV_NONE) ? in_bit
                 : ^({in_bit, enc_cur} & (q.half ? CONV_G1 : CONV_G0));
  assign last_coded = (q.conv == CONV_NONE) || q.half;

  // A byte ends on the last chip of the spread run of its last coded position
  assign byte_end = coding && q.cur_v && (q.chip_cnt == q.spread_factor - SF_1)
                    && last_coded && (q.bit_cnt == BIT_LAST);
  assign part_end = byte_end && q.cur_last;

  always_comb
  begin
    next_q = q;
    next_q.chip_v = 1'b0;
    next_q.done = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (START)
        begin
          next_q.st = ST_PRE;
          next_q.rate = RATE;
          next_q.lfsr = SEED_PRE;
          next_q.pre_cnt = 16'(PRE_CHIPS - 1);
          next_q.phase = 2'h0;
          next_q.chip_cnt = 5'h00;
          next_q.cur_v = 1'b0;
          next_q.hold_v = 1'b0;
        end
      end
      ST_PRE:
      begin
        // Constant 1 data: chip equals generator bit
        next_q.chip_v = 1'b1;
        next_q.chip.value = gen_bit;
        next_q.chip.phase = q.phase;
        next_q.phase = q.phase + 2'h1;
        next_q.lfsr = gen_step;
        if (q.pre_cnt == 16'h0000)
        begin
          next_q.st = ST_HDR;
          next_q.lfsr = SEED_HDR;
          next_q.spread_factor = SF_16;
          next_q.conv = CONV_SINGLE;
          next_q.enc_a = 2'h0;
          next_q.enc_b = 2'h0;
          next_q.enc_sel = 1'b0;
          next_q.half = 1'b0;
          next_q.bit_cnt = 3'h0;
          next_q.chip_cnt = 5'h00;
        end
        else
        begin
          next_q.pre_cnt = q.pre_cnt - 16'h0001;
        end
      end
      ST_HDR, ST_PAY:
      begin
        if (q.cur_v)
        begin
          next_q.chip_v = 1'b1;
          next_q.chip.value = ~(coded ^ gen_bit);
          next_q.chip.phase = q.phase;
          next_q.phase = q.phase + 2'h1;
          next_q.lfsr = gen_step;
          if (q.chip_cnt == q.spread_factor - SF_1)
          begin
            next_q.chip_cnt = 5'h00;
            if (last_coded)
            begin
              if (q.conv == CONV_DUAL && q.enc_sel)
                next_q.enc_b = {in_bit, q.enc_b[1]};
              else if (q.conv != CONV_NONE)
                next_q.enc_a = {in_bit, q.enc_a[1]};
              if (q.conv == CONV_DUAL)
                next_q.enc_sel = ~q.enc_sel;
              next_q.half = 1'b0;
              next_q.cur_byte = {q.cur_byte[6:0], 1'b0};
              next_q.bit_cnt = q.bit_cnt + 3'h1;
              if (byte_end)
                next_q.cur_v = 1'b0;
            end
            else
            begin
              next_q.half = 1'b1;
            end
          end
          else
          begin
            next_q.chip_cnt = q.chip_cnt + 5'h01;
          end
        end
        if (part_end && q.st == ST_HDR)
        begin
          next_q.st = ST_PAY;
          next_q.lfsr = SEED_PAY;
          next_q.spread_factor = rate_sf(q.rate);
          next_q.conv = rate_conv(q.rate);
          next_q.enc_a = 2'h0;
          next_q.enc_b = 2'h0;
          next_q.enc_sel = 1'b0;
          next_q.half = 1'b0;
          next_q.bit_cnt = 3'h0;
        end
        else if (part_end)
        begin
          next_q.st = ST_IDLE;
          next_q.done = 1'b1;
        end
        else if ((!q.cur_v || byte_end) && q.hold_v)
        begin
          next_q.cur_v = 1'b1;
          next_q.cur_byte = q.hold.data;
          next_q.cur_last = q.hold.last;
          next_q.bit_cnt = 3'h0;
          next_q.hold_v = 1'b0;
        end
        if (fetch_ok && src_v && !part_end)
        begin
          next_q.hold_v = 1'b1;
          next_q.hold = src_b;
        end
      end
      default:
      begin
        next_q.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      q <= '0;
      q.st <= ST_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule // txfec_chain

// ===== sim/txfec_chain_checker.sv
// Port assertions of the transmit coding chain
`timescale 1ns/1ns
module txfec_chk #(parameter int PRE_CHIPS = 512)
(
  input wire logic                   CLK_SYS,
  input wire logic                   RST,
  input wire logic                   START,
  input wire txfec_pkg::txfec_rate_t RATE,
  input wire logic                   IN_VALID,
  input wire txfec_pkg::txfec_byte_t IN_BYTE,
  input wire logic                   IN_READY,
  input wire logic                   CHIP_VALID,
  input wire txfec_pkg::txfec_chip_t CHIP,
  input wire logic                   BUSY,
  input wire logic                   DONE
);
  import txfec_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic [17:0] pl;
    logic        seen;
    logic [1:0]  ph;
  } txfec_chk_t;
  txfec_chk_t h;
  txfec_chk_t next_h;

  // Chip count, preamble sequence and last phase since packet start
  always_comb
  begin
    next_h = h;
    if (START && !BUSY)
    begin
      next_h.cnt  = '0;
      next_h.pl   = SEED_PRE;
      next_h.seen = 1'b0;
    end
    else if (CHIP_VALID)
    begin
      next_h.cnt  = h.cnt + 32'h1;
      next_h.seen = 1'b1;
      next_h.ph   = CHIP.phase;
      if (h.cnt < PRE_CHIPS)
        next_h.pl = {h.pl[16:0], h.pl[17] ^ h.pl[LFSR_TAP_A] ^ h.pl[LFSR_TAP_B] ^ h.pl[LFSR_TAP_C]};
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      h <= '0;
    else
      h <= next_h;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_begin;
    START && !BUSY;
  endsequence
  sequence s_turns;
    CHIP_VALID && BUSY && CHIP.phase == 2'h0 ##1 CHIP_VALID && CHIP.phase == 2'h1
    ##1 CHIP_VALID && CHIP.phase == 2'h2 ##1 CHIP_VALID && CHIP.phase == 2'h3;
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0) RST |=> !CHIP_VALID && !BUSY && !DONE && !IN_READY)
    else $error("outputs active after reset");
  a_start_turns: assert property (s_begin |=> ##1 s_turns)
    else $error("packet start chips wrong");
  a_phase_step: assert property (CHIP_VALID && h.seen |-> CHIP.phase == h.ph + 2'h1)
    else $error("chip phase did not advance");
  a_pre_chip: assert property (CHIP_VALID && h.cnt < PRE_CHIPS |-> CHIP.value == h.pl[17])
    else $error("preamble chip wrong");
  a_ready_window: assert property (IN_READY |-> BUSY && next_h.cnt >= PRE_CHIPS)
    else $error("byte accepted outside data parts");
  a_one_byte: assert property (IN_VALID && IN_READY ##1 IN_VALID && IN_READY |=> !IN_READY)
    else $error("third byte taken back to back");
  a_done_pulse: assert property (DONE |-> h.cnt > PRE_CHIPS ##1 !DONE)
    else $error("done pulse wrong");
  a_chip_busy: assert property (CHIP_VALID && !DONE |-> BUSY)
    else $error("chip outside packet");
  a_done_chip: assert property (DONE |-> CHIP_VALID && !BUSY)
    else $error("done without final chip");
endmodule // txfec_chk

bind txfec_chain txfec_chk #(.PRE_CHIPS(PRE_CHIPS)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .START(START), .RATE(RATE), .IN_VALID(IN_VALID), .IN_BYTE(IN_BYTE),
  .IN_READY(IN_READY), .CHIP_VALID(CHIP_VALID), .CHIP(CHIP), .BUSY(BUSY), .DONE(DONE));

// ===== sim/txfec_src_model.sv
// Byte source standing in for the link layer framing logic
`timescale 1ns/1ns
module txfec_src_model (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             go,
  input  wire logic             slow,
  input  wire integer           n_hdr,
  input  wire integer           n_pay,
  input  wire logic             ready,
  output logic                  valid,
  output txfec_pkg::txfec_byte_t bytes
);
  import txfec_pkg::*;
  int   idx;
  logic gap;

  initial
  begin
    valid = 1'b0;
    bytes = '0;
    idx   = 0;
    gap   = 1'b0;
  end

  // Holds each byte until taken; idle lines toggle
  always @(posedge clk)
  begin : step
    int k;
    k = idx + ((valid && ready) ? 1 : 0);
    gap <= ~gap;
    if (rst || go)
    begin
      idx   <= 0;
      valid <= 1'b0;
    end
    else if (!valid || ready)
    begin
      idx <= k;
      if (k < n_hdr + n_pay && !(slow && gap))
      begin
        valid <= 1'b1;
        bytes <= {8'(k) * 8'h3B ^ 8'hA5, k == n_hdr - 1 || k == n_hdr + n_pay - 1};
      end
      else
      begin
        valid <= 1'b0;
        bytes <= ~bytes;
      end
    end
  end
endmodule // txfec_src_model

// ===== sim/testbench.sv
// Self-checking bench of the transmit coding chain
`timescale 1ns/1ns
module testbench;
  import txfec_pkg::*;
  localparam int PRE = 8;
  localparam int NH  = 2;
  typedef struct {txfec_rate_t rate; int sf; txfec_conv_t conv; int npay; logic slow;} txfec_row_t;
  txfec_row_t rows[5] = '{
    '{RATE_522, 1, CONV_NONE, 225, 1'b0},
    '{RATE_261, 1, CONV_DUAL, 3, 1'b1},
    '{RATE_130, 2, CONV_SINGLE, 2, 1'b0},
    '{RATE_65, 4, CONV_SINGLE, 2, 1'b1},
    '{RATE_32, 8, CONV_SINGLE, 1, 1'b0}};
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        start   = 1'b0;
  txfec_rate_t rate    = RATE_522;
  logic        go      = 1'b0;
  logic        slow    = 1'b0;
  int          n_pay   = 0;
  logic        in_valid, in_ready, chip_valid, busy, done;
  txfec_byte_t in_byte;
  txfec_chip_t chip;
  txfec_chip_t got[$];
  logic [2:0]  want[$];
  logic [7:0]  gen[17];
  logic [17:0] lf;
  logic [1:0]  cst[2];
  int          fail_count  = 0;
  int          checks_done = 0;

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
    if (chip_valid === 1'b1) got.push_back(chip);

  txfec_chain #(.PRE_CHIPS(PRE)) dut (.CLK_SYS(clk_sys), .RST(rst), .START(start), .RATE(rate),
    .IN_VALID(in_valid), .IN_BYTE(in_byte), .IN_READY(in_ready), .CHIP_VALID(chip_valid),
    .CHIP(chip), .BUSY(busy), .DONE(done));
  txfec_src_model src (.clk(clk_sys), .rst(rst), .go(go), .slow(slow), .n_hdr(NH), .n_pay(n_pay),
    .ready(in_ready), .valid(in_valid), .bytes(in_byte));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) p ^= a;
      a = a[7] ? {a[6:0], 1'b0} ^ RS_POLY_LOW : {a[6:0], 1'b0};
    end
    return p;
  endfunction

  // Generator with roots alpha^0 .. alpha^15
  task automatic make_gen;
    logic [7:0] root;
    gen = '{default: 8'h00};
    gen[0] = 8'h01;
    root = 8'h01;
    repeat (RS_PAR_BYTES)
    begin
      for (int j = 16; j > 0; j--) gen[j] = gen[j-1] ^ gm(gen[j], root);
      gen[0] = gm(gen[0], root);
      root = gm(root, RS_ALPHA);
    end
  endtask

  task automatic put(input logic b, input int sf);
    repeat (sf)
    begin
      want.push_back({~(b ^ lf[17]), 2'(want.size())});
      lf = {lf[16:0], lf[17] ^ lf[LFSR_TAP_A] ^ lf[LFSR_TAP_B] ^ lf[LFSR_TAP_C]};
    end
  endtask

  task automatic send(input logic [7:0] d, input txfec_conv_t cv, input int sf, inout int n);
    int e;
    for (int i = 7; i >= 0; i--)
    begin
      e = (cv == CONV_DUAL) ? n % 2 : 0;
      if (cv == CONV_NONE)
        put(d[i], sf);
      else
      begin
        put(d[i] ^ cst[e][0] ^ cst[e][1], sf);
        put(d[i] ^ cst[e][1], sf);
        cst[e] = {cst[e][0], d[i]};
      end
      n++;
    end
  endtask

  task automatic build(input int r);
    logic [7:0] msg[$];
    logic [7:0] par[16];
    logic [7:0] fb;
    int n;
    want.delete();
    lf = SEED_PRE;
    repeat (PRE) put(1'b1, 1);
    lf = SEED_HDR;
    cst = '{2'h0, 2'h0};
    n = 0;
    for (int k = 0; k < NH; k++) send(8'(k) * 8'h3B ^ 8'hA5, CONV_SINGLE, 16, n);
    lf = SEED_PAY;
    cst = '{2'h0, 2'h0};
    n = 0;
    for (int k = 0; k < rows[r].npay; k++)
    begin
      msg.push_back(8'(k + NH) * 8'h3B ^ 8'hA5);
      if (msg.size() == RS_MSG_BYTES || k == rows[r].npay - 1)
      begin
        par = '{default: 8'h00};
        foreach (msg[m])
        begin
          send(msg[m], rows[r].conv, rows[r].sf, n);
          fb = msg[m] ^ par[15];
          for (int j = 15; j > 0; j--) par[j] = par[j-1] ^ gm(fb, gen[j]);
          par[0] = gm(fb, gen[0]);
        end
        for (int j = 15; j >= 0; j--) send(par[j], rows[r].conv, rows[r].sf, n);
        msg.delete();
      end
    end
  endtask

  task automatic run(input int r, input logic twice);
    int w;
    repeat (2) @(negedge clk_sys);
    start = 1'b1;
    rate  = rows[r].rate;
    n_pay = rows[r].npay;
    slow  = rows[r].slow;
    go    = 1'b1;
    got.delete();
    @(negedge clk_sys);
    start = 1'b0;
    go    = 1'b0;
    if (twice)
    begin
      repeat (3) @(negedge clk_sys);
      start = 1'b1;
      rate  = RATE_522;
      @(negedge clk_sys);
      start = 1'b0;
    end
    w = 0;
    while (done !== 1'b1 && w < 20000)
    begin
      @(negedge clk_sys);
      w++;
    end
    chk("done", {31'h0, done}, 32'h1);
    // Final chip is queued at the next rising edge
    @(negedge clk_sys);
    build(r);
    chk("chip count", 32'(got.size()), 32'(want.size()));
    foreach (want[i]) chk("chip", {29'h0, got[i]}, {29'h0, want[i]});
  endtask

  initial
  begin
    make_gen();
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk("idle outputs", {28'h0, chip_valid, busy, done, in_ready}, 32'h0);
    for (int r = 0; r < 5; r++) run(r, 1'b0);
    run(4, 1'b1);
    // Reset in the middle of a preamble, then a clean packet
    @(negedge clk_sys);
    start = 1'b1;
    go    = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    go    = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("reset outputs", {28'h0, chip_valid, busy, done, in_ready}, 32'h0);
    rst = 1'b0;
    run(1, 1'b0);
    report_and_stop();
  end

  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule // testbench
